// ===== src/bridge_link_map.svh
`ifndef BRIDGE_LINK_MAP_SVH
`define BRIDGE_LINK_MAP_SVH

// Link command and byte-lane codes, as driven on the active-low C/BE lines
`define CMD_IO_READ 4'h2
`define BE_ALL_LANES 4'h0
// Level a released line shows (pull-ups)
`define AD_IDLE 32'hffff_ffff
`define CBE_IDLE 4'hf
// Vector handed to a processor that loses the claim or finds no answer
`define PASSIVE_VECTOR 32'h0000_00ff
// Link clocks the master waits for a claim before giving up
`define DEVSEL_WAIT 3'h5
// System clocks the request line is ignored after end-of-interrupt
`define EOI_GUARD 8'h40
// Vector numbering of the interrupt controller
`define VEC_BASE 8'h20
`define SPURIOUS_VECTOR 8'h07
`define VEC_MSB 7
`define CPU_ID_W 2
`define IRQ_LINES 8

`endif

// ===== src/bridge_link_pkg.sv
package bridge_link_pkg;
`include "bridge_link_map.svh"

typedef enum logic [2:0] {S_TRACK, S_CLAIMED, S_READY, S_EOI, S_SETTLE} sys_phase_t;
typedef enum logic [1:0] {P_IDLE, P_ADDR, P_DATA, P_TURN} mst_phase_t;
typedef enum logic [1:0] {T_IDLE, T_CLAIM, T_RETRY, T_DONE} tgt_phase_t;

// One agent's drive of the shared lines: value and enable per line
typedef struct packed {
    logic [31:0] ad;
    logic ad_oe;
    logic [3:0] cbe;
    logic cbe_oe;
    logic par;
    logic par_oe;
    logic frame_n;
    logic frame_oe;
    logic irdy_n;
    logic irdy_oe;
    logic trdy_n;
    logic trdy_oe;
    logic stop_n;
    logic stop_oe;
    logic devsel_n;
    logic devsel_oe;
} pci_drive_t;

// Resolved levels of the shared lines
typedef struct packed {
    logic [31:0] ad;
    logic [3:0] cbe;
    logic par;
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic stop_n;
    logic devsel_n;
    logic lock_n;
} pci_bus_t;

typedef struct packed {
    sys_phase_t phase;
    logic [`CPU_ID_W-1:0] owner;
    logic req_tgl;
    logic done_seen;
    logic [31:0] addr;
    logic [31:0] vec;
    logic [7:0] guard;
    logic irq_out_n;
    logic err_n;
    logic resp_valid;
    logic resp_retry;
    logic resp_passive;
    logic [31:0] resp_vec;
} sys_state_t;

typedef struct packed {
    mst_phase_t pst;
    logic req_seen;
    logic pend;
    logic done_tgl;
    logic [2:0] timer;
    logic [31:0] vec;
    pci_drive_t drv;
} mst_state_t;

typedef struct packed {
    tgt_phase_t tst;
    logic in_service;
    logic frame_prev;
    logic int_req;
    logic nmi;
    pci_drive_t drv;
} tgt_state_t;

endpackage

// ===== src/bridge_pci_port.sv
`timescale 1ns/1ps
`include "bridge_link_map.svh"
module bridge_pci_port (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic pci_clk,
    input wire logic rst_link_b,
    pci_link_if.bridge link,
    input wire logic cpu_rd,
    input wire logic [`CPU_ID_W-1:0] cpu_id,
    input wire logic cpu_eoi,
    input wire logic [31:0] vector_fetch_addr,
    input wire logic nmi_enable,
    output logic resp_valid,
    output logic resp_retry,
    output logic resp_passive,
    output logic [31:0] resp_vector,
    output logic cpu_irq_request_n,
    output logic error_interrupt_n
);
    import bridge_link_pkg::*;

    sys_state_t s_r;
    sys_state_t s_nxt;
    mst_state_t p_r;
    mst_state_t p_nxt;
    logic irq_s;
    logic nmi_s;
    logic done_s;
    logic req_s;

    ////////////////////////////////////////////////////////////////////////
    // Crossings: levels and toggles through two flops each
    sync2 #(.W(3)) u_to_sys (
        .clk(clk_sys),
        .rst_b(rst_b),
        .d({link.int_req, link.nmi, p_r.done_tgl}),
        .q({irq_s, nmi_s, done_s})
    );

    sync2 #(.W(1)) u_to_link (
        .clk(pci_clk),
        .rst_b(rst_link_b),
        .d(s_r.req_tgl),
        .q(req_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // System side: claim, answers to processors, interrupt lines
    always_comb begin
        s_nxt = s_r;
        s_nxt.resp_valid = 1'b0;
        s_nxt.resp_retry = 1'b0;
        s_nxt.resp_passive = 1'b0;
        s_nxt.err_n = ~(nmi_s & nmi_enable);
        // Link word is held stable once its toggle is seen
        if (done_s != s_r.done_seen) begin
            s_nxt.done_seen = done_s;
            s_nxt.vec = p_r.vec;
            s_nxt.phase = S_READY;
        end
        if (cpu_rd) begin
            s_nxt.resp_valid = 1'b1;
            s_nxt.resp_vec = `PASSIVE_VECTOR;
        end
        unique case (s_nxt.phase)
            S_TRACK: begin
                if (cpu_rd) begin
                    s_nxt.owner = cpu_id;
                    s_nxt.addr = vector_fetch_addr;
                    s_nxt.req_tgl = ~s_r.req_tgl;
                    s_nxt.resp_retry = 1'b1;
                    s_nxt.phase = S_CLAIMED;
                end
            end
            S_CLAIMED: begin
                if (cpu_rd) begin
                    s_nxt.resp_retry = (cpu_id == s_r.owner);
                    s_nxt.resp_passive = (cpu_id != s_r.owner);
                end
            end
            S_READY: begin
                if (cpu_rd && cpu_id == s_r.owner) begin
                    s_nxt.resp_vec = s_nxt.vec;
                    s_nxt.owner = '0;
                    s_nxt.phase = S_EOI;
                end else if (cpu_rd) begin
                    s_nxt.resp_passive = 1'b1;
                end
            end
            S_EOI: begin
                s_nxt.resp_passive = cpu_rd;
                if (cpu_eoi) begin
                    s_nxt.guard = '0;
                    s_nxt.phase = S_SETTLE;
                end
            end
            S_SETTLE: begin
                // Stale request still in the synchroniser must not re-raise
                s_nxt.resp_passive = cpu_rd;
                s_nxt.guard = s_r.guard + 8'h01;
                if (s_r.guard == `EOI_GUARD - 8'h01) begin
                    s_nxt.phase = S_TRACK;
                end
            end
            default: begin
                s_nxt.phase = S_TRACK;
            end
        endcase
        // Line follows the request only while nothing is claimed
        s_nxt.irq_out_n = ~((s_nxt.phase == S_TRACK) & irq_s);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s_r <= '{phase: S_TRACK, irq_out_n: 1'b1, err_n: 1'b1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link side: single-word I/O read master
    always_comb begin
        p_nxt = p_r;
        if (req_s != p_r.req_seen) begin
            p_nxt.req_seen = req_s;
            p_nxt.pend = 1'b1;
        end
        unique case (p_r.pst)
            P_IDLE: begin
                p_nxt.drv = '0;
                if (p_nxt.pend) begin
                    // Address word held still by the system side until done
                    p_nxt.drv.ad = s_r.addr;
                    p_nxt.drv.ad_oe = 1'b1;
                    p_nxt.drv.cbe = `CMD_IO_READ;
                    p_nxt.drv.cbe_oe = 1'b1;
                    p_nxt.drv.frame_n = 1'b0;
                    p_nxt.drv.frame_oe = 1'b1;
                    p_nxt.drv.irdy_n = 1'b1;
                    p_nxt.drv.irdy_oe = 1'b1;
                    p_nxt.pst = P_ADDR;
                end
            end
            P_ADDR: begin
                p_nxt.drv.frame_n = 1'b1;
                p_nxt.drv.irdy_n = 1'b0;
                p_nxt.drv.ad_oe = 1'b0;
                p_nxt.drv.cbe = `BE_ALL_LANES;
                p_nxt.drv.par = ^{p_r.drv.ad, p_r.drv.cbe};
                p_nxt.drv.par_oe = 1'b1;
                p_nxt.timer = '0;
                p_nxt.pst = P_DATA;
            end
            P_DATA: begin
                // Read data parity belongs to the target
                p_nxt.drv.par_oe = 1'b0;
                p_nxt.timer = p_r.timer + 3'h1;
                if (!link.bus.irdy_n && !link.bus.trdy_n) begin
                    p_nxt.vec = link.bus.ad;
                    p_nxt.done_tgl = ~p_r.done_tgl;
                    p_nxt.pend = 1'b0;
                    p_nxt.pst = P_TURN;
                end else if (!link.bus.stop_n) begin
                    // Retry: request stays pending and is issued again
                    p_nxt.pst = P_TURN;
                end else if (link.bus.devsel_n && p_r.timer == `DEVSEL_WAIT) begin
                    p_nxt.vec = `PASSIVE_VECTOR;
                    p_nxt.done_tgl = ~p_r.done_tgl;
                    p_nxt.pend = 1'b0;
                    p_nxt.pst = P_TURN;
                end
                // Ready drops as the phase ends, so no further phase is implied
                if (p_nxt.pst == P_TURN) begin
                    p_nxt.drv.irdy_n = 1'b1;
                end
            end
            P_TURN: begin
                // Drive high one clock before release
                p_nxt.drv.irdy_n = 1'b1;
                p_nxt.drv.cbe_oe = 1'b0;
                p_nxt.pst = P_IDLE;
            end
        endcase
    end

    always_ff @(posedge pci_clk) begin
        if (!rst_link_b) begin
            p_r <= '{pst: P_IDLE, default: '0};
        end else begin
            p_r <= p_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops
    assign link.br_drv = p_r.drv;
    assign resp_valid = s_r.resp_valid;
    assign resp_retry = s_r.resp_retry;
    assign resp_passive = s_r.resp_passive;
    assign resp_vector = s_r.resp_vec;
    assign cpu_irq_request_n = s_r.irq_out_n;
    assign error_interrupt_n = s_r.err_n;
endmodule

// ===== src/irq_ctrl_end.sv
`timescale 1ns/1ps
`include "bridge_link_map.svh"
module irq_ctrl_end #(
    parameter int N = `IRQ_LINES
) (
    input wire logic pci_clk,
    input wire logic rst_link_b,
    pci_link_if.ctrl link,
    input wire logic [N-1:0] irq_lines,
    input wire logic specific_end_of_interrupt,
    input wire logic nmi_in,
    input wire logic [31:0] vec_reg_addr,
    output logic in_service
);
    import bridge_link_pkg::*;

    tgt_state_t c_r;
    tgt_state_t c_nxt;

    // Lowest line number wins; nothing pending gives the spurious code
    function automatic logic [7:0] vector_of(input logic [N-1:0] lines);
        logic [7:0] v;
        v = `SPURIOUS_VECTOR;
        for (int i = N - 1; i >= 0; i--) begin
            if (lines[i]) begin
                v = `VEC_BASE + 8'(i);
            end
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request and vector read target
    always_comb begin
        c_nxt = c_r;
        c_nxt.frame_prev = link.bus.frame_n;
        c_nxt.nmi = nmi_in;
        if (specific_end_of_interrupt) begin
            c_nxt.in_service = 1'b0;
        end
        // Request drops while in service and during end-of-interrupt
        c_nxt.int_req = (|irq_lines) & ~c_r.in_service & ~specific_end_of_interrupt;
        unique case (c_r.tst)
            T_IDLE: begin
                c_nxt.drv = '0;
                // Address phase: frame newly low; lock ignored, access is not exclusive
                if (!link.bus.frame_n && c_r.frame_prev && link.bus.cbe == `CMD_IO_READ
                        && link.bus.ad == vec_reg_addr) begin
                    c_nxt.drv.devsel_n = 1'b0;
                    c_nxt.drv.devsel_oe = 1'b1;
                    c_nxt.drv.trdy_oe = 1'b1;
                    c_nxt.drv.stop_oe = 1'b1;
                    if (specific_end_of_interrupt) begin
                        // Mid end-of-interrupt the vector is not settled
                        c_nxt.drv.trdy_n = 1'b1;
                        c_nxt.drv.stop_n = 1'b0;
                        c_nxt.tst = T_RETRY;
                    end else begin
                        c_nxt.drv.trdy_n = 1'b0;
                        c_nxt.drv.stop_n = 1'b1;
                        c_nxt.drv.ad = {24'h00_0000, vector_of(irq_lines)};
                        c_nxt.drv.ad_oe = 1'b1;
                        c_nxt.tst = T_CLAIM;
                    end
                end
            end
            T_CLAIM: begin
                // Word moves only with both ready lines low
                if (!link.bus.irdy_n) begin
                    c_nxt.in_service = 1'b1;
                    c_nxt.drv.ad_oe = 1'b0;
                    c_nxt.drv.trdy_n = 1'b1;
                    c_nxt.drv.devsel_n = 1'b1;
                    c_nxt.drv.par = ^{c_r.drv.ad, link.bus.cbe};
                    c_nxt.drv.par_oe = 1'b1;
                    c_nxt.tst = T_DONE;
                end
            end
            T_RETRY: begin
                c_nxt.drv.stop_n = 1'b1;
                c_nxt.drv.devsel_n = 1'b1;
                c_nxt.tst = T_DONE;
            end
            T_DONE: begin
                // Lines were driven high for a clock; now release
                c_nxt.drv = '0;
                c_nxt.tst = T_IDLE;
            end
        endcase
    end

    always_ff @(posedge pci_clk) begin
        if (!rst_link_b) begin
            c_r <= '{tst: T_IDLE, frame_prev: 1'b1, default: '0};
        end else begin
            c_r <= c_nxt;
        end
    end

    assign link.ct_drv = c_r.drv;
    assign link.int_req = c_r.int_req;
    assign link.nmi = c_r.nmi;
    assign in_service = c_r.in_service;
endmodule

// ===== src/pci_link_if.sv
`timescale 1ns/1ps
`include "bridge_link_map.svh"
interface pci_link_if;
    import bridge_link_pkg::*;

    pci_drive_t br_drv;
    pci_drive_t ct_drv;
    pci_bus_t bus;
    logic int_req;
    logic nmi;

    // Wire resolution; a released line floats high through its pull-up
    assign bus.ad = br_drv.ad_oe ? br_drv.ad : (ct_drv.ad_oe ? ct_drv.ad : `AD_IDLE);
    assign bus.cbe = br_drv.cbe_oe ? br_drv.cbe : (ct_drv.cbe_oe ? ct_drv.cbe : `CBE_IDLE);
    assign bus.par = br_drv.par_oe ? br_drv.par : (ct_drv.par_oe ? ct_drv.par : 1'b1);
    assign bus.frame_n = br_drv.frame_oe ? br_drv.frame_n
                       : (ct_drv.frame_oe ? ct_drv.frame_n : 1'b1);
    assign bus.irdy_n = br_drv.irdy_oe ? br_drv.irdy_n : (ct_drv.irdy_oe ? ct_drv.irdy_n : 1'b1);
    assign bus.trdy_n = br_drv.trdy_oe ? br_drv.trdy_n : (ct_drv.trdy_oe ? ct_drv.trdy_n : 1'b1);
    assign bus.stop_n = br_drv.stop_oe ? br_drv.stop_n : (ct_drv.stop_oe ? ct_drv.stop_n : 1'b1);
    assign bus.devsel_n = br_drv.devsel_oe ? br_drv.devsel_n
                        : (ct_drv.devsel_oe ? ct_drv.devsel_n : 1'b1);
    // No agent here takes the lock
    assign bus.lock_n = 1'b1;

    modport bridge (output br_drv, input bus, input int_req, input nmi);
    modport ctrl (output ct_drv, output int_req, output nmi, input bus);
endinterface

// ===== src/sync2.sv
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [1:0][W-1:0] stg_r;
    logic [1:0][W-1:0] stg_nxt;

    // First stage feeds only the second
    always_comb begin
        stg_nxt = {stg_r[0], d};
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stg_r <= '0;
        end else begin
            stg_r <= stg_nxt;
        end
    end

    assign q = stg_r[1];
endmodule

// ===== tb/bridge_link_props.sv
`timescale 1ns/1ps
`include "bridge_link_map.svh"
module bridge_link_props (
    input wire logic pci_clk,
    input wire logic rst_link_b,
    input wire bridge_link_pkg::pci_drive_t br_drv,
    input wire bridge_link_pkg::pci_drive_t ct_drv,
    input wire bridge_link_pkg::pci_bus_t bus
);
    import bridge_link_pkg::*;

    // Whole checker lives in the link domain
    default clocking cb @(posedge pci_clk);
    endclocking
    default disable iff (!rst_link_b);

    ////////////////////////////////////////////////////////////////////////////////
    // Address phase and command
    chk_addr_cmd: assert property ($fell(bus.frame_n) |->
        br_drv.ad_oe && bus.cbe == `CMD_IO_READ)
        else $error("address phase without master io read command");
    // Single word read, so the first data phase is already the last
    chk_frame_last: assert property ($fell(bus.frame_n) |=>
        bus.frame_n && !bus.irdy_n)
        else $error("frame still low in the only data phase");
    chk_lanes_all: assert property ((br_drv.irdy_oe && !bus.irdy_n) |->
        bus.cbe == `BE_ALL_LANES)
        else $error("byte enables not all lanes while master ready");

    ////////////////////////////////////////////////////////////////////////////////
    // Parity follows its data one clock later, from the right driver
    chk_addr_par: assert property ($fell(bus.frame_n) |=> br_drv.par_oe &&
        bus.par == (^{$past(bus.ad), $past(bus.cbe)}))
        else $error("address parity wrong or not master driven");
    chk_read_par: assert property ((!bus.irdy_n && !bus.trdy_n) |=>
        ct_drv.par_oe && bus.par == (^{$past(bus.ad), $past(bus.cbe)}))
        else $error("read data parity wrong or not target driven");

    ////////////////////////////////////////////////////////////////////////////////
    // Handshake: ready ends only after a word, a stop or an unclaimed wait
    chk_irdy_hold: assert property ($rose(bus.irdy_n) |->
        $past(!bus.trdy_n || !bus.stop_n || bus.devsel_n))
        else $error("master ready dropped before the word moved");
    chk_irdy_release: assert property ((!bus.irdy_n && !bus.trdy_n) |=> bus.irdy_n)
        else $error("master ready still low after the last word");
    chk_stop_retry: assert property (!bus.stop_n |-> bus.trdy_n && ct_drv.stop_oe)
        else $error("stop seen together with target ready");
    chk_claim_decode: assert property ($fell(bus.devsel_n) |->
        $past(bus.frame_n) == 1'b0 && $past(bus.cbe) == `CMD_IO_READ)
        else $error("claim without a decoded address phase");

    // Main scenarios reached
    cov_addr: cover property ($fell(bus.frame_n));
    cov_xfer: cover property (!bus.irdy_n && !bus.trdy_n);
    cov_stop: cover property (!bus.stop_n);
    cov_abort: cover property ((!bus.irdy_n && bus.devsel_n) [*3]);
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
`include "bridge_link_map.svh"
module testbench;
    import bridge_link_pkg::*;
    logic clk_sys = 1'b0;
    logic pci_clk = 1'b0;
    logic rst_b = 1'b0;
    logic rst_link_b = 1'b0;
    logic cpu_rd = 1'b0;
    logic [`CPU_ID_W-1:0] cpu_id = 2'h0;
    logic cpu_eoi = 1'b0;
    logic [31:0] vector_fetch_addr = 32'h0000_0420;
    logic nmi_enable = 1'b0;
    logic [7:0] irq_lines = 8'h00;
    logic eoi_cmd = 1'b0;
    logic nmi_in = 1'b0;
    logic [31:0] vec_reg_addr = 32'h0000_0420;
    logic resp_valid, resp_retry, resp_passive, cpu_irq_request_n, error_interrupt_n;
    logic in_service;
    logic [31:0] resp_vector;
    logic frame_q = 1'b1;
    logic stop_seen = 1'b0;
    logic [31:0] addr_seen = 32'h0000_0000;
    logic [31:0] data_seen = 32'h0000_0000;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    localparam logic [31:0] PV = `PASSIVE_VECTOR;

    ////////////////////////////////////////////////////////////////////////////////
    // Clocks; link clock offset so the two never line up
    always #5 clk_sys = ~clk_sys;
    always #80 pci_clk = ~pci_clk;

    // One master on the link, so there is no arbiter and no grant line
    pci_link_if link();
    bridge_pci_port bridge_pci_port_i(.clk_sys(clk_sys), .rst_b(rst_b), .pci_clk(pci_clk),
        .rst_link_b(rst_link_b), .link(link), .cpu_rd(cpu_rd), .cpu_id(cpu_id),
        .cpu_eoi(cpu_eoi), .vector_fetch_addr(vector_fetch_addr), .nmi_enable(nmi_enable),
        .resp_valid(resp_valid), .resp_retry(resp_retry), .resp_passive(resp_passive),
        .resp_vector(resp_vector), .cpu_irq_request_n(cpu_irq_request_n),
        .error_interrupt_n(error_interrupt_n));
    irq_ctrl_end irq_ctrl_end_i(.pci_clk(pci_clk), .rst_link_b(rst_link_b), .link(link),
        .irq_lines(irq_lines), .specific_end_of_interrupt(eoi_cmd), .nmi_in(nmi_in),
        .vec_reg_addr(vec_reg_addr), .in_service(in_service));
    bridge_link_props bridge_link_props_i(.pci_clk(pci_clk), .rst_link_b(rst_link_b),
        .br_drv(link.br_drv), .ct_drv(link.ct_drv), .bus(link.bus));

    // Wire watcher: address at frame start, word at transfer, any stop
    always @(posedge pci_clk) begin
        frame_q <= link.bus.frame_n;
        if (frame_q === 1'b1 && link.bus.frame_n === 1'b0) addr_seen <= link.bus.ad;
        if (link.bus.irdy_n === 1'b0 && link.bus.trdy_n === 1'b0) data_seen <= link.bus.ad;
        if (link.bus.stop_n === 1'b0) stop_seen <= 1'b1;
    end

    // Hang guard, well above the fewer than two thousand cycles the tests need
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One vector register read; answer lands on the same edge that takes it
    task automatic rd(input logic [1:0] id, input logic ex_retry, input logic ex_pass,
                      input logic [31:0] ex_vec);
        @(posedge clk_sys);
        cpu_rd <= 1'b1;
        cpu_id <= id;
        @(posedge clk_sys);
        cpu_rd <= 1'b0;
        #1;
        chk1("resp_valid", 1'b1, resp_valid);
        chk1("resp_retry", ex_retry, resp_retry);
        chk1("resp_passive", ex_pass, resp_passive);
        chk32("resp_vector", ex_vec, resp_vector);
    endtask

    // Link register plus two sync stages plus output register
    task automatic lwait();
        repeat (3) @(posedge pci_clk);
        repeat (6) @(posedge clk_sys);
    endtask

    // Bounded wait for the controller to take the read, then let done cross
    task automatic wait_svc();
        for (int i = 0; i < 400 && in_service !== 1'b1; i++) @(posedge clk_sys);
        chk1("in_service", 1'b1, in_service);
        lwait();
    endtask

    // End of interrupt on both sides; the line's own device drops too
    task automatic eoi();
        @(posedge pci_clk);
        eoi_cmd <= 1'b1;
        irq_lines <= 8'h00;
        @(posedge pci_clk);
        eoi_cmd <= 1'b0;
        @(posedge clk_sys);
        cpu_eoi <= 1'b1;
        @(posedge clk_sys);
        cpu_eoi <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge pci_clk);
        rst_link_b <= 1'b1;
        lwait();
        chk1("cpu_irq_request_n", 1'b1, cpu_irq_request_n);
        chk1("error_interrupt_n", 1'b1, error_interrupt_n);
        chk1("in_service", 1'b0, in_service);
        $display("test reset done");

        // Error line only for an enabled NMI, all four combinations
        for (int k = 0; k < 4; k++) begin
            @(posedge pci_clk);
            nmi_in <= k[0];
            @(posedge clk_sys);
            nmi_enable <= k[1];
            lwait();
            chk1("error_interrupt_n", !(k[0] && k[1]), error_interrupt_n);
        end
        @(posedge pci_clk);
        nmi_in <= 1'b0;
        $display("test nmi done");

        // Full vector fetch with a competing processor
        @(posedge pci_clk);
        irq_lines <= 8'h08;
        lwait();
        chk1("cpu_irq_request_n", 1'b0, cpu_irq_request_n);
        rd(2'h1, 1'b1, 1'b0, PV);
        repeat (4) @(posedge clk_sys);
        chk1("cpu_irq_request_n", 1'b1, cpu_irq_request_n);
        rd(2'h2, 1'b0, 1'b1, PV);
        wait_svc();
        chk32("link address", vector_fetch_addr, addr_seen);
        chk32("link data", {24'h00_0000, `VEC_BASE + 8'h03}, data_seen);
        rd(2'h2, 1'b0, 1'b1, PV);
        rd(2'h1, 1'b0, 1'b0, {24'h00_0000, `VEC_BASE + 8'h03});
        rd(2'h1, 1'b0, 1'b1, PV);
        eoi();
        chk1("int_req", 1'b0, link.int_req);
        repeat (20) @(posedge clk_sys);
        chk1("cpu_irq_request_n", 1'b1, cpu_irq_request_n);
        @(posedge pci_clk);
        irq_lines <= 8'h04;
        repeat (3) @(posedge pci_clk);
        repeat (60) @(posedge clk_sys);
        chk1("cpu_irq_request_n", 1'b0, cpu_irq_request_n);
        $display("test vector fetch done");

        // Controller busy with end-of-interrupt refuses the read by stop
        @(posedge pci_clk);
        eoi_cmd <= 1'b1;
        lwait();
        chk1("int_req", 1'b0, link.int_req);
        rd(2'h0, 1'b1, 1'b0, PV);
        repeat (12) @(posedge pci_clk);
        chk1("stop_seen", 1'b1, stop_seen);
        @(posedge pci_clk);
        eoi_cmd <= 1'b0;
        wait_svc();
        rd(2'h0, 1'b0, 1'b0, {24'h00_0000, `VEC_BASE + 8'h02});
        eoi();
        $display("test stop retry done");

        // Nobody claims the read: master abort yields the passive vector
        @(posedge pci_clk);
        vec_reg_addr <= 32'h0000_0430;
        irq_lines <= 8'h01;
        repeat (70) @(posedge clk_sys);
        lwait();
        chk1("cpu_irq_request_n", 1'b0, cpu_irq_request_n);
        rd(2'h3, 1'b1, 1'b0, PV);
        repeat (16) @(posedge pci_clk);
        repeat (8) @(posedge clk_sys);
        chk1("in_service", 1'b0, in_service);
        rd(2'h3, 1'b0, 1'b0, PV);
        eoi();
        $display("test master abort done");
        finish_test();
    end
endmodule
